// ===== hdl/dlso_pkg.sv
// Shared constants, opcodes and carrier types for the display list sequencer
package dlso_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PC = 8'h08;
  localparam logic [7:0] OFS_SP = 8'h0C;
  localparam logic [7:0] OFS_GR_BASE = 8'h10;

  // Control register fields
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_BANK_LO = 2;

  // Status register fields
  localparam int STAT_HALTED_BIT = 0;
  localparam int STAT_WAITING_BIT = 1;
  localparam int STAT_DISPMAP_BIT = 2;
  localparam int STAT_LINKHALT_BIT = 3;

  // Reset values
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [17:0] SP_RST = 18'h0_0000;
  localparam logic [1:0] BANK_RST = 2'h0;

  // Opcode field is first-word bits 15..6
  localparam int OPC_LO = 6;
  localparam logic [9:0] OPC_HALT = 10'h000;
  localparam logic [9:0] OPC_JUMP_MARK_OP = 10'h010;
  localparam logic [9:0] OPC_LINK = 10'h020;
  localparam logic [9:0] OPC_LDR = 10'h030;
  localparam logic [9:0] OPC_LOAD_REG_IMM_OP = 10'h031;
  localparam logic [9:0] OPC_LOAD_STACK_PTR_EXT_OP = 10'h032;
  localparam logic [9:0] OPC_WAIT = 10'h038;
  localparam logic [9:0] OPC_VIDEO_REG_REFRESH_OP = 10'h03B;

  // Second-word address fields
  localparam int IND_BIT = 15;
  localparam logic [15:0] WORD_STEP = 16'h0002;

  typedef enum logic [3:0] {
    OP_HALT, OP_JUMP_MARK_OP, OP_LINK, OP_LDR, OP_LOAD_REG_IMM_OP, OP_LOAD_STACK_PTR_EXT_OP, OP_WAIT, OP_VIDEO_REG_REFRESH_OP, OP_OTHER
  } dlso_op_e;

  // Display memory request
  typedef struct packed {
    logic [17:0] addr;
    logic we;
    logic [15:0] wdata;
  } dlso_mem_req_s;

  // Display register write strobe
  typedef struct packed {
    logic vld;
    logic [5:0] idx;
    logic [15:0] data;
  } dlso_dreg_wr_s;

endpackage

// ===== hdl/dlso_core.sv
// Display list sequencer: fetch, decode and execute of sequence control ops
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
module dlso_core
  import dlso_pkg::*;
#(
  parameter int NUM_GR = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Display memory master
  output logic mem_req,
  output dlso_mem_req_s mem_cmd,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // Display processor link
  output logic halt_irq,
  // Video side
  input wire logic frame_sync,
  output logic disp_map_sel,
  output logic map_clear,
  output logic map_clear_sel,
  output logic video_reg_refresh,
  output dlso_dreg_wr_s dreg_wr,
  output logic [17:0] stack_ptr,
  output logic [1:0] stack_bank
);

  if (NUM_GR < 4 || NUM_GR > 64) begin : g_bad_num_gr
    $error("NUM_GR must lie between 4 and 64");
  end

  typedef enum logic [2:0] {S_HALT, S_FETCH1, S_FETCH2, S_IND, S_STORE, S_WAITF} dlso_state_e;

  // decode looks only at the opcode field
  function automatic dlso_op_e op_of(input logic [15:0] w);
    case (w[15:OPC_LO])
      OPC_HALT: op_of = OP_HALT;
      OPC_JUMP_MARK_OP: op_of = OP_JUMP_MARK_OP;
      OPC_LINK: op_of = OP_LINK;
      OPC_LDR: op_of = OP_LDR;
      OPC_LOAD_REG_IMM_OP: op_of = OP_LOAD_REG_IMM_OP;
      OPC_LOAD_STACK_PTR_EXT_OP: op_of = OP_LOAD_STACK_PTR_EXT_OP;
      OPC_WAIT: op_of = OP_WAIT;
      OPC_VIDEO_REG_REFRESH_OP: op_of = OP_VIDEO_REG_REFRESH_OP;
      default: op_of = OP_OTHER;
    endcase
  endfunction

  function automatic logic two_word(input dlso_op_e op);
    two_word = (op == OP_JUMP_MARK_OP) || (op == OP_LINK) || (op == OP_LDR) ||
               (op == OP_LOAD_REG_IMM_OP) || (op == OP_LOAD_STACK_PTR_EXT_OP);
  endfunction

  dlso_state_e state_q;
  dlso_op_e op_q;
  logic [15:0] pc_q, w1_q;
  logic [17:0] sp_q, tgt_q;
  logic [15:0] gr_q [NUM_GR];
  logic mem_req_q;
  dlso_mem_req_s mem_cmd_q;
  logic halt_irq_q, link_halt_q;
  logic ext_q;
  logic [1:0] bank_q;
  logic disp_map_q, map_clear_q, vid_upd_q;
  dlso_dreg_wr_s dreg_wr_q;
  logic fs_s1_q, fs_s2_q, fs_s3_q;
  logic a_vld_q, a_wr_q;
  logic [7:0] a_addr_q;
  logic [31:0] hrdata_q;
  logic restart, wr_pc, fs_rise, ack_ind;
  logic [15:0] pc_inc, tgt_lo;
  logic [31:0] rd_d;

  assign pc_inc = pc_q + WORD_STEP;
  assign restart = a_vld_q && a_wr_q && (a_addr_q == OFS_CTRL) && hwdata[CTRL_RESTART_BIT];
  assign wr_pc = a_vld_q && a_wr_q && (a_addr_q == OFS_PC);
  assign fs_rise = fs_s2_q && !fs_s3_q;
  // bit 15 is an indirect flag only with extended addressing off
  assign ack_ind = !ext_q && mem_rdata[IND_BIT];
  // storage locations are forced to even bytes
  assign tgt_lo = ext_q ? {mem_rdata[15:1], 1'b0} : {1'b0, mem_rdata[14:1], 1'b0};

  // Frame sync pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_s1_q <= 1'b0;
      fs_s2_q <= 1'b0;
      fs_s3_q <= 1'b0;
    end else begin
      fs_s1_q <= frame_sync;
      fs_s2_q <= fs_s1_q;
      fs_s3_q <= fs_s2_q;
    end
  end

  // Sequencer state, program counter and memory requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_HALT;
      op_q <= OP_OTHER;
      pc_q <= PC_RST;
      w1_q <= 16'h0000;
      tgt_q <= 18'h0_0000;
      mem_req_q <= 1'b0;
      mem_cmd_q <= '0;
      halt_irq_q <= 1'b0;
      link_halt_q <= 1'b0;
    end else begin
      halt_irq_q <= 1'b0;
      if (mem_ack) begin
        mem_req_q <= 1'b0;
      end
      case (state_q)
        S_HALT: begin
          if (wr_pc) begin
            pc_q <= hwdata[15:0];
          end
          if (restart) begin
            mem_req_q <= 1'b1;
            // Bank field written with the restart applies to the first fetch
            mem_cmd_q <= '{addr: {hwdata[CTRL_BANK_LO +: 2], pc_q}, we: 1'b0, wdata: 16'h0000};
            link_halt_q <= 1'b0;
            state_q <= S_FETCH1;
          end
        end
        S_FETCH1: begin
          if (mem_ack) begin
            w1_q <= mem_rdata;
            op_q <= op_of(mem_rdata);
            pc_q <= pc_inc;
            if (two_word(op_of(mem_rdata))) begin
              mem_req_q <= 1'b1;
              mem_cmd_q <= '{addr: {bank_q, pc_inc}, we: 1'b0, wdata: 16'h0000};
              state_q <= S_FETCH2;
            end else if (op_of(mem_rdata) == OP_HALT) begin
              halt_irq_q <= 1'b1;
              state_q <= S_HALT;
            end else if (op_of(mem_rdata) == OP_WAIT) begin
              state_q <= S_WAITF;
            end else begin
              mem_req_q <= 1'b1;
              mem_cmd_q <= '{addr: {bank_q, pc_inc}, we: 1'b0, wdata: 16'h0000};
            end
          end
        end
        S_FETCH2: begin
          if (mem_ack) begin
            pc_q <= pc_inc;
            mem_req_q <= 1'b1;
            if ((op_q == OP_JUMP_MARK_OP) || (op_q == OP_LINK)) begin
              if (ack_ind) begin
                // indirect pointer read in the bank register's bank
                mem_cmd_q <= '{addr: {bank_q, tgt_lo}, we: 1'b0, wdata: 16'h0000};
                state_q <= S_IND;
              end else begin
                // direct storage location lies in bank 0
                tgt_q <= {2'b00, tgt_lo};
                mem_cmd_q <= '{addr: {2'b00, tgt_lo}, we: 1'b1, wdata: pc_inc};
                state_q <= S_STORE;
              end
            end else begin
              // other two-word ops just move on
              mem_cmd_q <= '{addr: {bank_q, pc_inc}, we: 1'b0, wdata: 16'h0000};
              state_q <= S_FETCH1;
            end
          end
        end
        S_IND: begin
          if (mem_ack) begin
            mem_req_q <= 1'b1;
            if (ack_ind) begin
              mem_cmd_q <= '{addr: {bank_q, tgt_lo}, we: 1'b0, wdata: 16'h0000};
            end else begin
              tgt_q <= {bank_q, tgt_lo};
              mem_cmd_q <= '{addr: {bank_q, tgt_lo}, we: 1'b1, wdata: pc_q};
              state_q <= S_STORE;
            end
          end
        end
        S_STORE: begin
          if (mem_ack) begin
            if (op_q == OP_LINK) begin
              halt_irq_q <= 1'b1;
              link_halt_q <= 1'b1;
              state_q <= S_HALT;
            end else begin
              // resume just past the stored return address
              pc_q <= tgt_q[15:0] + WORD_STEP;
              mem_req_q <= 1'b1;
              mem_cmd_q <= '{addr: {bank_q, tgt_q[15:0] + WORD_STEP}, we: 1'b0,
                             wdata: 16'h0000};
              state_q <= S_FETCH1;
            end
          end
        end
        S_WAITF: begin
          // hold until the next frame sync pulse
          if (fs_rise) begin
            mem_req_q <= 1'b1;
            mem_cmd_q <= '{addr: {bank_q, pc_q}, we: 1'b0, wdata: 16'h0000};
            state_q <= S_FETCH1;
          end
        end
        default: state_q <= S_HALT;
      endcase
    end
  end

  // Mapping memory swap and video register refresh
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_map_q <= 1'b0;
      map_clear_q <= 1'b0;
      vid_upd_q <= 1'b0;
    end else begin
      // swap displayed map and clear the other one
      map_clear_q <= (state_q == S_WAITF) && fs_rise;
      if ((state_q == S_WAITF) && fs_rise) begin
        disp_map_q <= !disp_map_q;
      end
      // only the video register copy is signalled
      vid_upd_q <= (state_q == S_FETCH1) && mem_ack && (op_of(mem_rdata) == OP_VIDEO_REG_REFRESH_OP);
    end
  end

  // Display registers and stack pointer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= SP_RST;
      dreg_wr_q <= '0;
      for (int i = 0; i < NUM_GR; i++) begin
        gr_q[i] <= 16'h0000;
      end
    end else begin
      dreg_wr_q.vld <= 1'b0;
      if ((state_q == S_FETCH2) && mem_ack) begin
        if (op_q == OP_LOAD_REG_IMM_OP) begin
          dreg_wr_q <= '{vld: 1'b1, idx: w1_q[5:0], data: mem_rdata};
          for (int i = 0; i < NUM_GR; i++) begin
            if (w1_q[5:0] == 6'(i)) begin
              gr_q[i] <= mem_rdata;
            end
          end
        end
        if (op_q == OP_LOAD_STACK_PTR_EXT_OP) begin
          // high address bits only with extended addressing
          sp_q <= {(ext_q ? w1_q[1:0] : 2'b00), mem_rdata};
        end
      end
    end
  end

  // AHB-Lite address phase capture and control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_vld_q <= 1'b0;
      a_wr_q <= 1'b0;
      a_addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      ext_q <= 1'b0;
      bank_q <= BANK_RST;
    end else begin
      a_vld_q <= hsel && hready && htrans[1] && (haddr[31:8] == 24'h00_0000);
      a_wr_q <= hwrite;
      a_addr_q <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        hrdata_q <= rd_d;
      end
      if (a_vld_q && a_wr_q && (a_addr_q == OFS_CTRL)) begin
        ext_q <= hwdata[CTRL_EXT_BIT];
        bank_q <= hwdata[CTRL_BANK_LO +: 2];
      end
    end
  end

  // Register read mux, unmapped reads give zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CTRL: rd_d = {28'h000_0000, bank_q, ext_q, 1'b0};
      OFS_STATUS: rd_d = {28'h000_0000, link_halt_q, disp_map_q,
                          state_q == S_WAITF, state_q == S_HALT};
      OFS_PC: rd_d = {16'h0000, pc_q};
      OFS_SP: rd_d = {14'h0000, sp_q};
      default: begin
        for (int i = 0; i < NUM_GR; i++) begin
          if (haddr[7:0] == OFS_GR_BASE + 8'(4 * i)) begin
            rd_d = {16'h0000, gr_q[i]};
          end
        end
      end
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      rd_d = 32'h0000_0000;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign mem_req = mem_req_q;
  assign mem_cmd = mem_cmd_q;
  assign halt_irq = halt_irq_q;
  assign disp_map_sel = disp_map_q;
  assign map_clear = map_clear_q;
  assign map_clear_sel = !disp_map_q;
  assign video_reg_refresh = vid_upd_q;
  assign dreg_wr = dreg_wr_q;
  assign stack_ptr = sp_q;
  // stack accesses use the bank register
  assign stack_bank = bank_q;

  a_link_halt: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_STORE && mem_ack && op_q == OP_LINK) |=> (state_q == S_HALT && halt_irq))
    else $error("linkage did not halt with interrupt");

  a_jump_mark_op_pc: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_STORE && mem_ack && op_q == OP_JUMP_MARK_OP) |=>
      (pc_q == $past(mem_cmd_q.addr[15:0]) + 16'h0002))
    else $error("jump-and-mark program counter wrong");

  a_direct_bank: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_FETCH2 && mem_ack && (op_q == OP_LINK || op_q == OP_JUMP_MARK_OP) && !ack_ind)
      |=> (mem_cmd_q.we && mem_cmd_q.addr[17:16] == 2'b00 && !mem_cmd_q.addr[0]))
    else $error("direct store not in bank 0 or odd");

  a_ext_no_ind: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_FETCH2 && mem_ack && ext_q && op_q == OP_JUMP_MARK_OP) |=> state_q == S_STORE)
    else $error("extended addressing took indirect path");

  a_halt_op: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_FETCH1 && mem_ack && mem_rdata[15:6] == OPC_HALT) |=>
      (state_q == S_HALT && halt_irq) ##1 !halt_irq)
    else $error("halt op did not stop with one interrupt pulse");

  // swap pairs with a clear of the other map
  a_map_swap: assert property (@(posedge hclk) disable iff (!hresetn)
    map_clear |-> ($changed(disp_map_sel) && map_clear_sel != disp_map_sel))
    else $error("map clear without swap");

  // register load takes the second word
  a_load_reg_imm_op_load: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_FETCH2 && mem_ack && op_q == OP_LOAD_REG_IMM_OP) |=>
      (dreg_wr.vld && dreg_wr.data == $past(mem_rdata) && dreg_wr.idx == $past(w1_q[5:0])))
    else $error("register load strobe wrong");

  a_sp_load: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_FETCH2 && mem_ack && op_q == OP_LOAD_STACK_PTR_EXT_OP) |=>
      (sp_q[15:0] == $past(mem_rdata) && sp_q[17:16] == ($past(ext_q) ? $past(w1_q[1:0]) : 2'b00)))
    else $error("stack pointer load wrong");

  // device register load leaves stack pointer and display registers alone
  a_ldr_noop: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_FETCH2 && mem_ack && op_q == OP_LDR) |=>
      ($stable(sp_q) && !dreg_wr.vld && state_q == S_FETCH1))
    else $error("load device register had an effect");

  // wait leaves only on a frame sync edge
  a_wait_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_q == S_WAITF && !fs_rise) |=> state_q == S_WAITF)
    else $error("wait left without frame sync");

endmodule

// ===== bench/dlso_mem_model.sv
// Display memory responder with varying latency, standing in for the far side
module dlso_mem_model
  import dlso_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request from the sequencer
  input wire logic mem_req,
  input wire dlso_mem_req_s mem_cmd,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:131071];
  logic [1:0] lat_q;
  logic [1:0] cnt_q;
  // Latency walks 0..3; read data is scrambled whenever it is not valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      lat_q <= 2'h0;
      cnt_q <= 2'h0;
      mem_rdata <= 16'h5a5a;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_req && cnt_q == lat_q) begin
      mem_ack <= 1'b1;
      cnt_q <= 2'h0;
      lat_q <= lat_q + 2'h1;
      if (mem_cmd.we) begin
        mem[mem_cmd.addr[17:1]] <= mem_cmd.wdata;
        mem_rdata <= ~mem_rdata;
      end else begin
        mem_rdata <= mem[mem_cmd.addr[17:1]];
      end
    end else begin
      cnt_q <= mem_req ? cnt_q + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ===== bench/display_list_sequence_ops_tb_top.sv
// Self-checking bench for the display list sequencer
module display_list_sequence_ops_tb_top
  import dlso_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic frame_sync = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, mem_req, mem_ack, halt_irq, disp_map_sel;
  logic map_clear, map_clear_sel, video_reg_refresh;
  logic [15:0] mem_rdata;
  logic [17:0] stack_ptr;
  logic [1:0] stack_bank;
  dlso_mem_req_s mem_cmd;
  dlso_dreg_wr_s dreg_wr;
  logic [35:0] exp_q [$];
  logic [15:0] rnd = 16'h0059;
  logic [15:0] gr_val [0:3];
  logic rd_dp = 1'b0;
  int errors = 0;
  int comparisons = 0;

  always #2 hclk = ~hclk;

  dlso_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .halt_irq(halt_irq), .frame_sync(frame_sync),
    .disp_map_sel(disp_map_sel), .map_clear(map_clear), .map_clear_sel(map_clear_sel),
    .video_reg_refresh(video_reg_refresh), .dreg_wr(dreg_wr), .stack_ptr(stack_ptr),
    .stack_bank(stack_bank));

  dlso_mem_model mdl (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic note(input logic [35:0] got);
    if (exp_q.size() == 0) begin
      errors++;
      $display("BAD %0t unexpected event %h", $time, got);
    end else begin
      chk(got, exp_q.pop_front());
    end
  endtask

  // Observed events: 1 register load, 2 halt, 3 video refresh, 4 map swap, 5 read data
  always @(posedge hclk) begin
    if (hresetn) begin
      if (rd_dp && hreadyout) note({4'h5, hrdata});
      rd_dp = htrans[1] && !hwrite && hreadyout;
      if (dreg_wr.vld) note({4'h1, 10'h000, dreg_wr.idx, dreg_wr.data});
      if (halt_irq) note({4'h2, 32'h0000_0000});
      if (video_reg_refresh) note({4'h3, 32'h0000_0000});
      if (map_clear) note({4'h4, 30'h0000_0000, map_clear_sel, disp_map_sel});
    end
  end

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    if (!wr) exp_q.push_back({4'h5, d});
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0000_0000;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask

  task automatic put(input logic [17:0] a, input logic [15:0] w);
    mdl.mem[a[17:1]] = w;
  endtask

  task automatic mem_is(input logic [17:0] a, input logic [15:0] w);
    chk({20'h0_0000, mdl.mem[a[17:1]]}, {20'h0_0000, w});
  endtask

  task automatic run_to_halt();
    int n;
    n = 0;
    @(posedge hclk);
    while (halt_irq !== 1'b1 && n < 400) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 400) errors++;
    @(posedge hclk);
  endtask

  task automatic stop_test();
    if (errors == 0 && comparisons > 0 && exp_q.size() == 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #(4 * 20000);
    errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_0004, 32'h0000_0001);
    ahb(1'b0, 32'h0000_0100, 32'h0000_0000);
    // Refresh file with loads, jumps, linkage, one frame wait and a halt
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      gr_val[i] = rnd;
      put(18'(4 * i), 16'h0c40 | 16'(i));
      put(18'(4 * i + 2), rnd);
      exp_q.push_back({4'h1, 10'h000, 6'(i), rnd});
    end
    put(18'h00010, 16'h0c2b);
    put(18'h00012, lfsr(rnd));
    put(18'h00014, 16'h0ec5);
    put(18'h00016, 16'h0415);
    put(18'h00018, 16'h0100);
    put(18'h00102, 16'h0400);
    put(18'h00104, 16'h8200);
    put(18'h00200, 16'h8210);
    put(18'h00210, 16'h0300);
    put(18'h00302, 16'h082a);
    put(18'h00304, 16'h0400);
    put(18'h00306, 16'h0e3f);
    put(18'h00308, 16'h003f);
    exp_q.push_back({4'h3, 32'h0000_0000});
    exp_q.push_back({4'h2, 32'h0000_0000});
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    run_to_halt();
    mem_is(18'h00100, 16'h001a);
    mem_is(18'h00300, 16'h0106);
    mem_is(18'h00400, 16'h0306);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0009);
    for (int i = 0; i < 4; i++) ahb(1'b0, 32'(16 + 4 * i), {16'h0000, gr_val[i]});
    exp_q.push_back({4'h4, 32'h0000_0001});
    exp_q.push_back({4'h2, 32'h0000_0000});
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    repeat (40) @(posedge hclk);
    frame_sync <= 1'b1;
    repeat (4) @(posedge hclk);
    frame_sync <= 1'b0;
    run_to_halt();
    ahb(1'b0, 32'h0000_0004, 32'h0000_0005);
    // Extended addressing in bank 1: stack load, jump-and-mark, direct linkage
    put(18'h11000, 16'h0c82);
    put(18'h11002, 16'h5678);
    put(18'h11004, 16'h0400);
    put(18'h11006, 16'h8400);
    put(18'h18402, 16'h0800);
    put(18'h18404, 16'h0600);
    exp_q.push_back({4'h2, 32'h0000_0000});
    ahb(1'b1, 32'h0000_0008, 32'h0000_1000);
    ahb(1'b1, 32'h0000_0000, 32'h0000_0007);
    run_to_halt();
    chk({18'h0_0000, stack_ptr}, {18'h0_0000, 18'h2_5678});
    chk({34'h0_0000_0000, stack_bank}, {34'h0_0000_0000, 2'h1});
    ahb(1'b0, 32'h0000_000c, 32'h0002_5678);
    mem_is(18'h08400, 16'h1008);
    mem_is(18'h00600, 16'h8406);
    ahb(1'b0, 32'h0000_0004, 32'h0000_000d);
    chk({32'h0000_0000, 3'h0, hresp}, {32'h0000_0000, 4'h0});
    repeat (4) @(posedge hclk);
    stop_test();
  end
endmodule
